// ### src/dbta_map.vh
// register offsets, field positions, reset values, burst sizes and response codes of the dma arbiter
`ifndef DBTA_MAP_VH
`define DBTA_MAP_VH
// register byte offsets
`define DBTA_CTRL_OFS         12'h000
`define DBTA_STAT_OFS         12'h004
// control register fields
`define DBTA_LOW_LSB          0
`define DBTA_HIGH_LSB         3
`define DBTA_EN_BIT           6
`define DBTA_RXBST_LSB        8
`define DBTA_TXBST_LSB        10
// control register reset value: both burst codes 3, thresholds 0, enable 0
`define DBTA_CTRL_RST         32'h00000F00
// control register writable bits
`define DBTA_CTRL_MASK        32'h00000F7F
// status register fields
`define DBTA_ST_RXPRI_BIT     0
`define DBTA_ST_RXGNT_BIT     1
`define DBTA_ST_TXGNT_BIT     2
`define DBTA_ST_RR_BIT        3
// burst length in bytes for code 0, doubling per code step
`define DBTA_BURST_BASE       10'h040
// burst limit shown while in reset: code 3, 512 bytes
`define DBTA_BURST_RST        10'h200
// axi response codes
`define DBTA_RESP_OKAY        2'h0
`define DBTA_RESP_SLVERR      2'h2
`endif

// ### src/dbta_level_cmp.v
// compares rx fifo occupancy against a threshold code given in eighths
`timescale 1ns/1ps
module dbta_level_cmp (
    // fifo state
    input  wire [15:0] FILL,
    input  wire [15:0] DEPTH,
    // threshold code, n eighths
    input  wire [2:0]  CODE,
    // comparison results
    output wire        AT_OR_ABOVE,
    output wire        AT_OR_BELOW
);
    // threshold level = depth * code / 8, done in 19 bits to keep all bits
    wire [18:0] prod;
    wire [15:0] level;
    assign prod  = DEPTH * CODE;
    assign level = prod[18:3];
    // occupancy compared both ways
    assign AT_OR_ABOVE = (FILL >= level);
    assign AT_OR_BELOW = (FILL <= level);
endmodule

// ### src/dbta_arbiter.v
// dma burst length control and rx/tx channel arbitration with axi4-lite registers
`timescale 1ns/1ps
`include "dbta_map.vh"
module dbta_arbiter (
    // clock and reset
    input  wire        CLOCK,
    input  wire        RST,
    // axi4-lite write address
    input  wire        S_AXI_AWVALID,
    output reg         S_AXI_AWREADY,
    input  wire [11:0] S_AXI_AWADDR,
    // axi4-lite write data
    input  wire        S_AXI_WVALID,
    output reg         S_AXI_WREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    // axi4-lite write response
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    output reg  [1:0]  S_AXI_BRESP,
    // axi4-lite read address
    input  wire        S_AXI_ARVALID,
    output reg         S_AXI_ARREADY,
    input  wire [11:0] S_AXI_ARADDR,
    // axi4-lite read data
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY,
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    // rx fifo state, same clock
    input  wire [15:0] RX_FIFO_FILL,
    input  wire [15:0] RX_FIFO_DEPTH,
    // requests from the dma engines, same clock
    input  wire        RX_DMA_REQ,
    input  wire        TX_DMA_REQ,
    // channel grants
    output reg         RX_DMA_GNT,
    output reg         TX_DMA_GNT,
    // burst limits in bytes
    output reg  [9:0]  RX_BURST_BYTES,
    output reg  [9:0]  TX_BURST_BYTES,
    // current priority, high while rx is favoured
    output reg         RX_PRIORITY
);
    // control register and its fields
    reg  [31:0] ctrl_q;
    wire        arb_en;
    wire [2:0]  rx_fill_high_mark;
    wire [2:0]  rx_fill_low_mark;
    wire [1:0]  rx_burst_length_sel;
    wire [1:0]  tx_burst_length_sel;
    // comparator results
    wire        above_high;
    wire        below_low;
    wire        unused_a;
    wire        unused_b;
    // arbitration state
    reg         rx_pri_q;             // hysteresis priority
    reg         rr_last_rx_q;         // round robin: last grant went to rx
    reg         rx_pri_d;
    reg         rx_gnt_d;
    reg         tx_gnt_d;
    // axi write capture
    reg         aw_got_q;
    reg  [11:0] aw_addr_q;
    reg         w_got_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;

    assign arb_en              = ctrl_q[`DBTA_EN_BIT];
    assign rx_fill_high_mark   = ctrl_q[`DBTA_HIGH_LSB +: 3];
    assign rx_fill_low_mark    = ctrl_q[`DBTA_LOW_LSB +: 3];
    assign rx_burst_length_sel = ctrl_q[`DBTA_RXBST_LSB +: 2];
    assign tx_burst_length_sel = ctrl_q[`DBTA_TXBST_LSB +: 2];

    // burst code to byte count: 64 << code
    function [9:0] burst_bytes;
        input [1:0] code;
        begin
            burst_bytes = `DBTA_BURST_BASE << code;
        end
    endfunction

    // word match of a bus address against a register byte offset, lanes ignored
    function reg_hit;
        input [11:0] addr;
        input [11:0] ofs;
        begin
            reg_hit = (addr[11:2] == ofs[11:2]);
        end
    endfunction

    // byte-lane merge of a write into a word
    function [31:0] strb_merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0]  strb;
        integer i;
        begin
            strb_merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    strb_merge[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    // high mark compare, n eighths of depth
    dbta_level_cmp u_high (
        .FILL        (RX_FIFO_FILL),
        .DEPTH       (RX_FIFO_DEPTH),
        .CODE        (rx_fill_high_mark),
        .AT_OR_ABOVE (above_high),
        .AT_OR_BELOW (unused_a)
    );

    // low mark compare, n eighths of depth
    dbta_level_cmp u_low (
        .FILL        (RX_FIFO_FILL),
        .DEPTH       (RX_FIFO_DEPTH),
        .CODE        (rx_fill_low_mark),
        .AT_OR_ABOVE (unused_b),
        .AT_OR_BELOW (below_low)
    );

    // priority and grant decision
    always @* begin
        rx_pri_d = rx_pri_q;
        rx_gnt_d = 1'b0;
        tx_gnt_d = 1'b0;
        if (arb_en) begin
            // a low mark not below the high mark is software misuse; low wins here
            if (below_low) begin
                rx_pri_d = 1'b0;
            end else if (above_high) begin
                rx_pri_d = 1'b1;
            end
            // priority engine wins when both request
            if (rx_pri_d) begin
                rx_gnt_d = RX_DMA_REQ;
                tx_gnt_d = TX_DMA_REQ & ~RX_DMA_REQ;
            end else begin
                tx_gnt_d = TX_DMA_REQ;
                rx_gnt_d = RX_DMA_REQ & ~TX_DMA_REQ;
            end
        end else begin
            // fair alternation, thresholds ignored
            rx_pri_d = 1'b0;
            if (RX_DMA_REQ && TX_DMA_REQ) begin
                rx_gnt_d = ~rr_last_rx_q;
                tx_gnt_d = rr_last_rx_q;
            end else begin
                rx_gnt_d = RX_DMA_REQ;
                tx_gnt_d = TX_DMA_REQ;
            end
        end
    end

    // arbitration registers and outputs
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            rx_pri_q       <= 1'b0;
            rr_last_rx_q   <= 1'b0;
            RX_DMA_GNT     <= 1'b0;
            TX_DMA_GNT     <= 1'b0;
            RX_PRIORITY    <= 1'b0;
            RX_BURST_BYTES <= `DBTA_BURST_RST;
            TX_BURST_BYTES <= `DBTA_BURST_RST;
        end else begin
            rx_pri_q       <= rx_pri_d;
            RX_PRIORITY    <= rx_pri_d;
            RX_DMA_GNT     <= rx_gnt_d;
            TX_DMA_GNT     <= tx_gnt_d;
            // remember winner for the round robin
            if (rx_gnt_d) begin
                rr_last_rx_q <= 1'b1;
            end else if (tx_gnt_d) begin
                rr_last_rx_q <= 1'b0;
            end
            RX_BURST_BYTES <= burst_bytes(rx_burst_length_sel);
            TX_BURST_BYTES <= burst_bytes(tx_burst_length_sel);
        end
    end

    // axi write path: take address and data in any order, answer after both
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= `DBTA_RESP_OKAY;
            aw_got_q      <= 1'b0;
            w_got_q       <= 1'b0;
            aw_addr_q     <= 12'h000;
            w_data_q      <= 32'h00000000;
            w_strb_q      <= 4'h0;
            ctrl_q        <= `DBTA_CTRL_RST;
        end else begin
            // ready pulses for one cycle when a channel is offered
            S_AXI_AWREADY <= S_AXI_AWVALID & ~aw_got_q & ~S_AXI_AWREADY & ~S_AXI_BVALID;
            S_AXI_WREADY  <= S_AXI_WVALID & ~w_got_q & ~S_AXI_WREADY & ~S_AXI_BVALID;
            // capture address
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_got_q  <= 1'b1;
                aw_addr_q <= S_AXI_AWADDR;
            end
            // capture data
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_got_q  <= 1'b1;
                w_data_q <= S_AXI_WDATA;
                w_strb_q <= S_AXI_WSTRB;
            end
            // both held: perform write and answer
            if (aw_got_q && w_got_q && !S_AXI_BVALID) begin
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                if (reg_hit(aw_addr_q, `DBTA_CTRL_OFS)) begin
                    ctrl_q      <= strb_merge(ctrl_q, w_data_q, w_strb_q) & `DBTA_CTRL_MASK;
                    S_AXI_BRESP <= `DBTA_RESP_OKAY;
                end else if (reg_hit(aw_addr_q, `DBTA_STAT_OFS)) begin
                    // status is read only, write dropped
                    S_AXI_BRESP <= `DBTA_RESP_OKAY;
                end else begin
                    // unmapped
                    S_AXI_BRESP <= `DBTA_RESP_SLVERR;
                end
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // axi read path: one cycle ready, data on the next
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h00000000;
            S_AXI_RRESP   <= `DBTA_RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= S_AXI_ARVALID & ~S_AXI_ARREADY & ~S_AXI_RVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP  <= `DBTA_RESP_OKAY;
                if (reg_hit(S_AXI_ARADDR, `DBTA_CTRL_OFS)) begin
                    S_AXI_RDATA <= ctrl_q;
                end else if (reg_hit(S_AXI_ARADDR, `DBTA_STAT_OFS)) begin
                    S_AXI_RDATA <= {28'h0000000, rr_last_rx_q, TX_DMA_GNT,
                                    RX_DMA_GNT, rx_pri_q};
                end else begin
                    S_AXI_RDATA <= 32'h00000000;
                    S_AXI_RRESP <= `DBTA_RESP_SLVERR;
                end
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end
endmodule

// ### tb/dbta_arb_properties.sv
// concurrent checks on the dma arbiter ports
`timescale 1ns/1ps
module dbta_arb_props (
    // clock, reset and bus answers
    input wire        CLOCK, RST, S_AXI_AWREADY, S_AXI_BVALID, S_AXI_BREADY,
    input wire [1:0]  S_AXI_BRESP,
    input wire        S_AXI_RVALID, S_AXI_RREADY,
    input wire [31:0] S_AXI_RDATA,
    // channel side
    input wire        RX_DMA_REQ, TX_DMA_REQ, RX_DMA_GNT, TX_DMA_GNT,
    input wire [9:0]  RX_BURST_BYTES, TX_BURST_BYTES
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    AST_ONE_GNT: assert property (!(RX_DMA_GNT && TX_DMA_GNT))
        else $error("both grants high");
    AST_RX_GNT_REQ: assert property (RX_DMA_GNT |-> $past(RX_DMA_REQ))
        else $error("rx grant without request");
    AST_TX_GNT_REQ: assert property (TX_DMA_GNT |-> $past(TX_DMA_REQ))
        else $error("tx grant without request");
    AST_NO_IDLE: assert property (RX_DMA_REQ || TX_DMA_REQ |=> RX_DMA_GNT || TX_DMA_GNT)
        else $error("request left without grant");
    AST_BURST_SET: assert property ($onehot(RX_BURST_BYTES)
        && RX_BURST_BYTES[5:0] == 6'h00
        && $onehot(TX_BURST_BYTES) && TX_BURST_BYTES[5:0] == 6'h00)
        else $error("burst limit not a legal size");
    AST_BURST_WR: assert property ($changed({RX_BURST_BYTES, TX_BURST_BYTES})
        |-> S_AXI_BVALID || $past(S_AXI_BVALID))
        else $error("burst limit moved without a write");
    AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY
        |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write answer dropped");
    AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY
        |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read answer dropped");
    AST_AW_PULSE: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY)
        else $error("address ready held");
endmodule
bind dbta_arbiter dbta_arb_props i_chk (.CLOCK, .RST, .S_AXI_AWREADY, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_BRESP, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA, .RX_DMA_REQ,
    .TX_DMA_REQ, .RX_DMA_GNT, .TX_DMA_GNT, .RX_BURST_BYTES, .TX_BURST_BYTES);

// ### tb/dbta_dma_model.sv
// receive and transmit dma engines that share the arbitrated channel
`timescale 1ns/1ps
module dbta_dma_model (
    // clock and reset
    input wire       CLOCK, RST,
    // bit 0 rx engine busy, bit 1 tx engine busy
    input wire [1:0] WANT,
    // grants in, requests and grant counts out
    input wire       RX_GNT, TX_GNT,
    output reg       RX_REQ, TX_REQ,
    output reg [7:0] RX_CNT, TX_CNT
);
    // a busy engine keeps asking; each granted cycle is one burst beat counted
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            {RX_REQ, TX_REQ, RX_CNT, TX_CNT} <= 18'h00000;
        end else begin
            {TX_REQ, RX_REQ} <= WANT;
            RX_CNT <= RX_CNT + RX_GNT;
            TX_CNT <= TX_CNT + TX_GNT;
        end
    end
endmodule

// ### tb/test_dbta_arbiter.sv
// self-checking bench of the dma arbiter
`timescale 1ns/1ps
module test_dbta_arbiter;
    logic CLOCK = 0, RST = 1, S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
    logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
    logic [11:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
    logic [31:0] S_AXI_WDATA = 0;
    logic [3:0]  S_AXI_WSTRB = 4'hF;
    logic [15:0] RX_FIFO_FILL = 0, RX_FIFO_DEPTH = 16'h0040;
    logic [1:0]  want = 0;
    wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    wire RX_DMA_REQ, TX_DMA_REQ, RX_DMA_GNT, TX_DMA_GNT, RX_PRIORITY;
    wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
    wire [31:0] S_AXI_RDATA;
    wire [9:0] RX_BURST_BYTES, TX_BURST_BYTES;
    wire [7:0] rx_cnt, tx_cnt;
    int n_errors = 0, n_tests = 0, r0, t0;
    dbta_arbiter i_dut (.CLOCK, .RST, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_AWADDR,
        .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_BVALID,
        .S_AXI_BREADY, .S_AXI_BRESP, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_ARADDR,
        .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA, .S_AXI_RRESP, .RX_FIFO_FILL,
        .RX_FIFO_DEPTH, .RX_DMA_REQ, .TX_DMA_REQ, .RX_DMA_GNT, .TX_DMA_GNT,
        .RX_BURST_BYTES, .TX_BURST_BYTES, .RX_PRIORITY);
    dbta_dma_model i_dma (.CLOCK, .RST, .WANT(want), .RX_GNT(RX_DMA_GNT),
        .TX_GNT(TX_DMA_GNT), .RX_REQ(RX_DMA_REQ), .TX_REQ(TX_DMA_REQ),
        .RX_CNT(rx_cnt), .TX_CNT(tx_cnt));
    initial begin
        forever #5 CLOCK = ~CLOCK;
    end
    task automatic conclude;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one write; address and data released as each is taken
    task automatic wr(input [11:0] a, input [31:0] d, input [1:0] er);
        int i;
        {S_AXI_AWADDR, S_AXI_WDATA} <= {a, d};
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'b111;
        for (i = 0; i < 40; i++) begin
            @(posedge CLOCK);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 0;
            if (S_AXI_BVALID) break;
        end
        if (i == 40) begin
            n_errors++;
            conclude();
        end
        chk(S_AXI_BRESP, er);
        S_AXI_BREADY <= 0;
        @(posedge CLOCK);
    endtask
    // one read, data and response compared
    task automatic rd(input [11:0] a, input [31:0] ed, input [1:0] er);
        int i;
        S_AXI_ARADDR <= a;
        {S_AXI_ARVALID, S_AXI_RREADY} <= 2'b11;
        for (i = 0; i < 40; i++) begin
            @(posedge CLOCK);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 0;
            if (S_AXI_RVALID) break;
        end
        if (i == 40) begin
            n_errors++;
            conclude();
        end
        chk(S_AXI_RDATA, ed);
        chk(S_AXI_RRESP, er);
        S_AXI_RREADY <= 0;
        @(posedge CLOCK);
    endtask
    // set fill, let it settle, check priority and contended grant
    task automatic step(input [15:0] f, input logic e);
        RX_FIFO_FILL <= f;
        repeat (3) @(posedge CLOCK);
        chk(RX_PRIORITY, e);
        chk(RX_DMA_GNT, e);
    endtask
    task automatic t_reset;
        RST <= 1;
        repeat (2) @(posedge CLOCK);
        RST <= 0;
        @(posedge CLOCK);
        chk(RX_BURST_BYTES, 10'h200);
        chk(TX_BURST_BYTES, 10'h200);
        rd(12'h000, 32'h00000F00, 2'h0);
        $display("reset test done");
    endtask
    task automatic t_burst;
        for (int c = 0; c < 4; c++) begin
            wr(12'h000, 32'hFFFFF080 | (3 - c) << 10 | c << 8, 2'h0);
            repeat (2) @(posedge CLOCK);
            chk(RX_BURST_BYTES, 64 << c);
            chk(TX_BURST_BYTES, 64 << (3 - c));
            rd(12'h000, (3 - c) << 10 | c << 8, 2'h0);
        end
        rd(12'h008, 32'h0, 2'h2);
        wr(12'h008, 32'h0, 2'h2);
        wr(12'h004, 32'hFFFFFFFF, 2'h0);
        rd(12'h000, 32'h00000300, 2'h0);
        // only lane 1 written: tx code 3, rx code 0, low byte kept
        S_AXI_WSTRB <= 4'h2;
        wr(12'h000, 32'hFFFFFCFF, 2'h0);
        S_AXI_WSTRB <= 4'hF;
        rd(12'h000, 32'h00000C00, 2'h0);
        $display("burst and bus test done");
    endtask
    task automatic t_hyst;
        want <= 2'b11;
        wr(12'h000, 32'h00000F72, 2'h0); // high 6/8 = 48, low 2/8 = 16
        step(47, 0);
        step(48, 1);
        step(17, 1);
        step(16, 0);
        step(30, 0);
        wr(12'h000, 32'h00000F78, 2'h0); // high 7/8 = 56, low 0
        step(55, 0);
        step(56, 1);
        // status: rr last rx, tx grant 0, rx grant 1, rx priority 1
        rd(12'h004, 32'h0000000B, 2'h0);
        step(1, 1);
        step(0, 0);
        // depth 44: 7/8 of it rounds down to 38
        RX_FIFO_DEPTH <= 16'h002C;
        step(37, 0);
        step(38, 1);
        $display("threshold test done");
    endtask
    task automatic t_rr;
        wr(12'h000, 32'h00000F3E, 2'h0); // enable clear, thresholds ignored
        RX_FIFO_FILL <= 16'h0040;
        repeat (2) @(posedge CLOCK);
        {r0, t0} = {24'h0, rx_cnt, 24'h0, tx_cnt};
        repeat (8) @(posedge CLOCK);
        chk(RX_PRIORITY, 0);
        chk(rx_cnt - r0, 4);
        chk(tx_cnt - t0, 4);
        $display("round robin test done");
    endtask
    initial begin
        repeat (2) @(posedge CLOCK);
        RST <= 0;
        @(posedge CLOCK);
        t_reset();
        t_burst();
        t_hyst();
        t_rr();
        want <= 2'b00;
        t_reset();
        conclude();
    end
endmodule
